// *** logic/usp_map.svh ***
// Timing and reset constants for the status and power pin block
`ifndef USP_MAP_SVH
`define USP_MAP_SVH
`define USP_CLK_HZ 10000000
`define USP_POR_DELAY_US 2000
`define USP_LED_MIN_US 50000
`define USP_SYNC_RST 2'b11
`define USP_SYNC_CLR 2'b00
`define USP_ONE_CNT 24'h000001
`define USP_ZERO_CNT 24'h000000
`endif

// *** logic/usp_pkg.sv ***
// Types shared by the status and power pin block
`include "usp_map.svh"
package usp_pkg;
   typedef enum logic [1:0] {
      USP_POR_HOLD,
      USP_POR_RUN
   } usp_por_state_t;
   typedef logic [23:0] usp_count_t;
endpackage : usp_pkg

// *** logic/usp_pulse_if.sv ***
// Trigger and pulse signals between the top and a pulse stretcher
`timescale 1ns/1ps
interface usp_pulse_if;
   logic trigger;
   logic active;
   modport owner (output trigger, input active);
   modport stretcher (input trigger, output active);
endinterface : usp_pulse_if

// *** logic/usp_pulse_stretch.sv ***
// Retriggerable pulse stretcher for an activity indicator
`timescale 1ns/1ps
`include "usp_map.svh"
module usp_pulse_stretch
   import usp_pkg::*;
#(
   parameter int LEN_CYCLES = 500000
) (
   input wire logic clock,
   input wire logic rst_b,
   usp_pulse_if.stretcher pulse
);
   initial begin
      if (LEN_CYCLES < 1 || LEN_CYCLES > 16777215) begin
         $error("usp_pulse_stretch: LEN_CYCLES out of range");
      end
   end
   localparam usp_count_t LenCount = usp_count_t'(LEN_CYCLES);
   usp_count_t countReg;
   logic activeReg;
   // Further traffic reloads the full length
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         countReg <= `USP_ZERO_CNT;
      end else if (pulse.trigger) begin
         countReg <= LenCount;
      end else if (countReg != `USP_ZERO_CNT) begin
         countReg <= countReg - `USP_ONE_CNT;
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         activeReg <= 1'b0;
      end else begin
         activeReg <= pulse.trigger || (countReg > `USP_ONE_CNT);
      end
   end
   assign pulse.active = activeReg;
endmodule : usp_pulse_stretch

// *** logic/usb_uart_status_power_pins.sv ***
// Status, reset and power-control pin logic of a USB serial bridge
`timescale 1ns/1ps
`include "usp_map.svh"
module usb_uart_status_power_pins
   import usp_pkg::*;
#(
   parameter int CLK_HZ = `USP_CLK_HZ,
   parameter int POR_CYCLES = (`USP_POR_DELAY_US * (`USP_CLK_HZ / 1000000)),
   parameter int LED_CYCLES = (`USP_LED_MIN_US * (`USP_CLK_HZ / 1000000))
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ext_reset_n,
   input wire logic supplyGood,
   input wire logic usbBusReset,
   input wire logic usbConfigured,
   input wire logic usbSuspended,
   input wire logic usbRxData,
   input wire logic usbTxData,
   input wire logic remoteWakeEnable,
   input wire logic ring_wake_n,
   input wire logic power_mode_strap,
   input wire logic serialTxBit,
   input wire logic serialTxBusy,
   input wire logic rxd,
   input wire logic rtsRequest,
   input wire logic dtrRequest,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic carrier_detect_n,
   output logic por_out_n,
   output logic por_out_oe_n,
   output logic internalReset_n,
   output logic sleep_n,
   output logic rx_activity_led_n,
   output logic rx_activity_led_oe_n,
   output logic tx_activity_led_n,
   output logic tx_activity_led_oe_n,
   output logic ext_power_en_n,
   output logic rs485_drive_en,
   output logic resumeRequest,
   output logic selfPowered,
   output logic txd,
   output logic rxData,
   output logic rts_n,
   output logic dtr_n,
   output logic ctsActive,
   output logic dsrActive,
   output logic carrierActive
);
   initial begin
      if (POR_CYCLES < 1 || POR_CYCLES > 16777215) begin
         $error("usb_uart_status_power_pins: POR_CYCLES out of range");
      end
      if (CLK_HZ < 1) begin
         $error("usb_uart_status_power_pins: CLK_HZ out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [1:0] extRstSyncReg;
   logic [1:0] supplySyncReg;
   logic [1:0] ringSyncReg;
   logic [1:0] strapSyncReg;
   logic [1:0] rxdSyncReg;
   logic [1:0] ctsSyncReg;
   logic [1:0] dsrSyncReg;
   logic [1:0] dcdSyncReg;

   // Idle pins come out of reset at their pulled-up level
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         extRstSyncReg <= `USP_SYNC_RST;
      end else begin
         extRstSyncReg <= {extRstSyncReg[0], ext_reset_n};
      end
   end

   // Supply counts as bad until seen good twice
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         supplySyncReg <= `USP_SYNC_CLR;
      end else begin
         supplySyncReg <= {supplySyncReg[0], supplyGood};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ringSyncReg <= `USP_SYNC_RST;
      end else begin
         ringSyncReg <= {ringSyncReg[0], ring_wake_n};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         strapSyncReg <= `USP_SYNC_CLR;
      end else begin
         strapSyncReg <= {strapSyncReg[0], power_mode_strap};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rxdSyncReg <= `USP_SYNC_RST;
      end else begin
         rxdSyncReg <= {rxdSyncReg[0], rxd};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctsSyncReg <= `USP_SYNC_RST;
      end else begin
         ctsSyncReg <= {ctsSyncReg[0], cts_n};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dsrSyncReg <= `USP_SYNC_RST;
      end else begin
         dsrSyncReg <= {dsrSyncReg[0], dsr_n};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dcdSyncReg <= `USP_SYNC_RST;
      end else begin
         dcdSyncReg <= {dcdSyncReg[0], carrier_detect_n};
      end
   end

   logic extResetActive;
   assign extResetActive = !extRstSyncReg[1];

   ////////////////////////////////////////////////////////////////////////////
   // Reset generator
   localparam usp_count_t PorCount = usp_count_t'(POR_CYCLES);
   usp_por_state_t porStateReg;
   usp_count_t porCountReg;

   // The bus reset input is deliberately not used here
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         porStateReg <= USP_POR_HOLD;
         porCountReg <= `USP_ZERO_CNT;
      end else if (extResetActive || !supplySyncReg[1]) begin
         porStateReg <= USP_POR_HOLD;
         porCountReg <= `USP_ZERO_CNT;
      end else begin
         unique case (porStateReg)
            USP_POR_HOLD: begin
               if (porCountReg >= PorCount - `USP_ONE_CNT) begin
                  porStateReg <= USP_POR_RUN;
               end else begin
                  porCountReg <= porCountReg + `USP_ONE_CNT;
               end
            end
            USP_POR_RUN: begin
               porStateReg <= USP_POR_RUN;
            end
         endcase
      end
   end

   // Released means enable high; when driving the level is high
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         por_out_oe_n <= 1'b1;
         por_out_n <= 1'b1;
         internalReset_n <= 1'b0;
      end else begin
         por_out_oe_n <= (porStateReg != USP_POR_RUN);
         por_out_n <= 1'b1;
         internalReset_n <= (porStateReg == USP_POR_RUN) && !extResetActive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Suspend, power enable and wakeup
   logic ringPrevReg;
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ringPrevReg <= 1'b1;
      end else begin
         ringPrevReg <= ringSyncReg[1];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sleep_n <= 1'b1;
         ext_power_en_n <= 1'b1;
         resumeRequest <= 1'b0;
         selfPowered <= 1'b0;
      end else begin
         sleep_n <= !usbSuspended;
         ext_power_en_n <= !(usbConfigured && !usbSuspended);
         resumeRequest <= remoteWakeEnable && usbSuspended
            && ringPrevReg && !ringSyncReg[1];
         selfPowered <= strapSyncReg[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Activity indicators
   usp_pulse_if rxPulse();
   usp_pulse_if txPulse();
   assign rxPulse.trigger = usbRxData;
   assign txPulse.trigger = usbTxData;

   usp_pulse_stretch #(.LEN_CYCLES(LED_CYCLES)) rxStretch (
      .clock(clock),
      .rst_b(rst_b),
      .pulse(rxPulse)
   );
   usp_pulse_stretch #(.LEN_CYCLES(LED_CYCLES)) txStretch (
      .clock(clock),
      .rst_b(rst_b),
      .pulse(txPulse)
   );

   // Open collector: only ever drives low, enable low while sinking
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_activity_led_oe_n <= 1'b1;
         tx_activity_led_oe_n <= 1'b1;
         rx_activity_led_n <= 1'b0;
         tx_activity_led_n <= 1'b0;
      end else begin
         rx_activity_led_oe_n <= !rxPulse.active;
         tx_activity_led_oe_n <= !txPulse.active;
         rx_activity_led_n <= 1'b0;
         tx_activity_led_n <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial data and modem lines
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         txd <= 1'b1;
         rxData <= 1'b1;
      end else begin
         txd <= serialTxBit;
         rxData <= rxdSyncReg[1];
      end
   end

   // Line driver enabled for the whole of a transmission
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rs485_drive_en <= 1'b0;
      end else begin
         rs485_drive_en <= serialTxBusy;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
      end else begin
         rts_n <= !rtsRequest;
         dtr_n <= !dtrRequest;
      end
   end

   // Incoming modem lines, reported active high
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctsActive <= 1'b0;
         dsrActive <= 1'b0;
         carrierActive <= 1'b0;
      end else begin
         ctsActive <= !ctsSyncReg[1];
         dsrActive <= !dsrSyncReg[1];
         carrierActive <= !dcdSyncReg[1];
      end
   end

   logic unusedBusReset;
   assign unusedBusReset = usbBusReset;
endmodule : usb_uart_status_power_pins

// *** test/usp_partner.sv ***
// Far-side model: serial transceiver loopback and ring source
`timescale 1ns/1ps
module usp_partner (
   input wire logic ringReq,
   input wire logic txd,
   input wire logic rts_n,
   input wire logic dtr_n,
   output logic rxd,
   output logic cts_n,
   output logic dsr_n,
   output logic carrier_detect_n,
   output logic ring_wake_n
);
   // Line returns what the device sends
   assign rxd = txd;
   assign cts_n = rts_n;
   assign dsr_n = dtr_n;
   assign carrier_detect_n = txd;
   // Ring idles high through its pull-up
   assign ring_wake_n = !ringReq;
endmodule : usp_partner

// *** test/usp_properties.sv ***
// Concurrent checks on the status and power pin block ports
`timescale 1ns/1ps
module usp_properties #(
   parameter int POR_CYCLES = 20000,
   parameter int LED_CYCLES = 500000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ext_reset_n,
   input wire logic supplyGood,
   input wire logic usbConfigured,
   input wire logic usbSuspended,
   input wire logic usbRxData,
   input wire logic usbTxData,
   input wire logic remoteWakeEnable,
   input wire logic serialTxBusy,
   input wire logic por_out_n,
   input wire logic por_out_oe_n,
   input wire logic sleep_n,
   input wire logic rx_activity_led_n,
   input wire logic rx_activity_led_oe_n,
   input wire logic tx_activity_led_n,
   input wire logic tx_activity_led_oe_n,
   input wire logic ext_power_en_n,
   input wire logic rs485_drive_en,
   input wire logic resumeRequest
);
   int porCnt_reg;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   ////////////////////
   // Cycles of good supply with the reset pin released
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) porCnt_reg <= 0;
      else if (!supplyGood || !ext_reset_n) porCnt_reg <= 0;
      else if (porCnt_reg < POR_CYCLES + 9) porCnt_reg <= porCnt_reg + 1;
   end
   ////////////////////
   a_sleep_mirror: assert property (1 |=> sleep_n == !$past(usbSuspended))
      else $error("sleep indicator wrong");
   a_power_enable: assert property (1 |=> ext_power_en_n ==
      !($past(usbConfigured) && !$past(usbSuspended))) else $error("power enable wrong");
   a_rs485_follow: assert property (1 |=> rs485_drive_en == $past(serialTxBusy))
      else $error("drive enable wrong");
   a_por_level: assert property (!por_out_oe_n |-> por_out_n)
      else $error("reset output level low");
   a_por_early: assert property ($fell(por_out_oe_n) |-> porCnt_reg >= POR_CYCLES)
      else $error("reset output driven too early");
   a_por_late: assert property (porCnt_reg == POR_CYCLES + 8 |-> !por_out_oe_n)
      else $error("reset output driven too late");
   a_bus_reset_ignore: assert property
      (!por_out_oe_n && ext_reset_n && supplyGood |=> !por_out_oe_n)
      else $error("reset output dropped");
   a_ext_release: assert property
      ($fell(ext_reset_n) || $fell(supplyGood) |-> ##[1:4] por_out_oe_n)
      else $error("reset output not released");
   a_rx_pulse: assert property
      (usbRxData |-> ##2 (!rx_activity_led_oe_n && !rx_activity_led_n)[*2])
      else $error("receive led not lit");
   a_tx_pulse: assert property
      (usbTxData |-> ##2 (!tx_activity_led_oe_n && !tx_activity_led_n)[*2])
      else $error("transmit led not lit");
   a_resume_pulse: assert property
      (resumeRequest |-> $past(usbSuspended) && $past(remoteWakeEnable) ##1 !resumeRequest)
      else $error("resume pulse wrong");
   c_resume: cover property (resumeRequest);
   c_por_drive: cover property ($fell(por_out_oe_n));
   c_both_leds: cover property (usbRxData && usbTxData);
endmodule : usp_properties

bind usb_uart_status_power_pins usp_properties #(
   .POR_CYCLES(POR_CYCLES),
   .LED_CYCLES(LED_CYCLES)
) chk_u (.*);

// *** test/testbench.sv ***
// Self-checking bench for the status and power pin block
`timescale 1ns/1ps
module testbench;
   localparam int POR = 10;
   localparam int LED = 4;
   logic clock, rst_b, ext_reset_n, supplyGood, usbBusReset, usbConfigured, usbSuspended;
   logic usbRxData, usbTxData, remoteWakeEnable, power_mode_strap, serialTxBit;
   logic serialTxBusy, rtsRequest, dtrRequest, ringReq;
   logic ring_wake_n, rxd, cts_n, dsr_n, carrier_detect_n;
   logic por_out_n, por_out_oe_n, internalReset_n, sleep_n, rx_activity_led_n;
   logic rx_activity_led_oe_n, tx_activity_led_n, tx_activity_led_oe_n, ext_power_en_n;
   logic rs485_drive_en, resumeRequest, selfPowered, txd, rxData, rts_n, dtr_n;
   logic ctsActive, dsrActive, carrierActive;
   logic [9:0] v;
   logic [9:0] e;
   logic [9:0] h[$];
   int failures, totalChecks, cycles, n, w;
   usb_uart_status_power_pins #(.POR_CYCLES(POR), .LED_CYCLES(LED)) dut_u (.*);
   usp_partner far_u (.*);
   ////////////////////
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         report_and_stop();
      end
   end
   ////////////////////
   task automatic chk(string nm, logic ex, logic got);
      totalChecks++;
      if (got !== ex) begin
         failures++;
         $display("Error %s expected %b seen %b", nm, ex, got);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d failures %0d", totalChecks, failures);
      if (failures == 0 && totalChecks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop
   // Waits for the reset output to drive, then checks the delay
   task automatic por_up();
      n = 0;
      while (por_out_oe_n !== 1'b0 && n < POR + 20) begin
         @(negedge clock);
         n++;
      end
      chk("por delay", 1'b1, n >= POR && n <= POR + 8);
      chk("por level", 1'b1, por_out_n);
      chk("int reset", 1'b1, internalReset_n);
   endtask : por_up
   task automatic led_chk(string nm, int b, logic oe);
      logic hit;
      hit = 1'b0;
      for (int j = 1; j < 11; j++) hit |= h[j][b];
      if (h[3][b]) chk(nm, 1'b0, oe);
      if (!hit) chk(nm, 1'b1, oe);
   endtask : led_chk
   ////////////////////
   initial begin
      {rst_b, usbBusReset, usbConfigured, usbSuspended, usbRxData, usbTxData} = '0;
      {remoteWakeEnable, power_mode_strap, serialTxBit, serialTxBusy} = '0;
      {rtsRequest, dtrRequest, ringReq} = '0;
      {ext_reset_n, supplyGood} = 2'b11;
      {failures, totalChecks, cycles} = '0;
      w = $urandom(78);
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         por_up();
         @(posedge clock);
         if (k == 0) ext_reset_n <= 1'b0;
         else supplyGood <= 1'b0;
         repeat (5) @(posedge clock);
         chk("por released", 1'b1, por_out_oe_n);
         chk("int reset held", 1'b0, internalReset_n);
         {ext_reset_n, supplyGood} <= 2'b11;
      end
      por_up();
      for (int i = 0; i < 300; i++) begin
         @(posedge clock);
         w = $urandom;
         v = w[9:0];
         v[7] = v[7] & w[10] & w[11];
         v[8] = v[8] & w[12] & w[13];
         {usbBusReset, usbTxData, usbRxData, power_mode_strap, dtrRequest, rtsRequest,
            serialTxBusy, serialTxBit, usbSuspended, usbConfigured} <= v;
         h.push_front(v);
         @(negedge clock);
         if (h.size() > 10) begin
            e = h[1];
            chk("sleep", !e[1], sleep_n);
            chk("power en", !(e[0] & !e[1]), ext_power_en_n);
            chk("rs485 en", e[3], rs485_drive_en);
            chk("txd", e[2], txd);
            chk("rts", !e[4], rts_n);
            chk("dtr", !e[5], dtr_n);
            chk("self pwr", h[3][6], selfPowered);
            chk("rx data", h[4][2], rxData);
            chk("cts", h[4][4], ctsActive);
            chk("dsr", h[4][5], dsrActive);
            chk("carrier", !h[4][2], carrierActive);
            chk("bus reset", 1'b0, por_out_oe_n);
            chk("rx led level", 1'b0, rx_activity_led_n);
            chk("tx led level", 1'b0, tx_activity_led_n);
            led_chk("rx led", 7, rx_activity_led_oe_n);
            led_chk("tx led", 8, tx_activity_led_oe_n);
         end
      end
      @(posedge clock);
      {usbRxData, usbTxData, usbBusReset} <= 3'b000;
      for (int k = 0; k < 3; k++) begin
         @(posedge clock);
         usbSuspended <= k != 2;
         remoteWakeEnable <= k != 1;
         repeat (4) @(posedge clock);
         ringReq <= 1'b1;
         n = 0;
         repeat (10) begin
            @(negedge clock);
            n += (resumeRequest === 1'b1);
         end
         chk("resume", 1'b1, n == (k == 0));
         @(posedge clock);
         ringReq <= 1'b0;
         repeat (4) @(posedge clock);
      end
      report_and_stop();
   end
endmodule : testbench
